// *** rtl/link_cfg_consts.vh ***
// Contract
// - local-ack bit set: slave acks locally while forward link down; resets one.
// - local-ack bit clear: no acknowledge while forward link down.
// - two-bit setup/hold select, four timing pairs, resets to 01.
// - three-bit master bit-rate select, 8.47 to 837 kbps, resets 101.
// - two-bit remote timeout: 64, 256, 1024 us or off; resets 10.
// - underflow bit zero: repeat last audio word when fifo empty.
// - underflow bit one: output zero word when fifo empty.
// - sck invert bit selects sck polarity, resets zero.
// - ws invert bit selects ws polarity, resets zero.
`ifndef LINK_CFG_CONSTS_VH
`define LINK_CFG_CONSTS_VH
`define OFS_BRIDGE_CFG 8'h1c
`define OFS_AUDIO_CFG 8'h1d
`define OFS_DEVICE_ID 8'h1e
`define BIT_LOCAL_ACK 7
`define MSB_SETUP_HOLD 6
`define LSB_SETUP_HOLD 5
`define MSB_BIT_RATE 4
`define LSB_BIT_RATE 2
`define MSB_TIMEOUT 1
`define LSB_TIMEOUT 0
`define BIT_UNDERFLOW 2
`define BIT_SCK_INV 1
`define BIT_WS_INV 0
`define RST_BRIDGE_CFG 8'hb6
`define RST_AUDIO_CFG 3'h0
`define RST_SETUP_HOLD 2'h1
`define RST_BIT_RATE 3'h5
`define RST_TIMEOUT_SEL 2'h2
`define RST_TIMEOUT_US 12'd1024
`define TIMEOUT_64US 12'd64
`define TIMEOUT_256US 12'd256
`define TIMEOUT_1024US 12'd1024
`define CLK_MHZ 32'd100
`endif

// *** rtl/audio_out_shaper.v ***
`timescale 1ns/10ps
`include "link_cfg_consts.vh"
module audio_out_shaper #(
    parameter WORD_W = 32
) (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire underflow_zero_i,
    input wire sck_invert_i,
    input wire ws_invert_i,
    input wire fifo_empty_i,
    input wire [WORD_W-1:0] fifo_word_i,
    input wire sck_i,
    input wire ws_i,
    output reg [WORD_W-1:0] audio_word_o,
    output reg sck_o,
    output reg ws_o
);
always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        audio_word_o <= {WORD_W{1'b0}};
        sck_o <= 1'b0;
        ws_o <= 1'b0;
    end else begin
        // empty and bit clear: last word holds
        if (!fifo_empty_i)
            audio_word_o <= fifo_word_i;
        else if (underflow_zero_i)
            audio_word_o <= {WORD_W{1'b0}};
        sck_o <= sck_i ^ sck_invert_i;
        ws_o <= ws_i ^ ws_invert_i;
    end
end
endmodule

// *** rtl/link_control_audio_config_regs.v ***
`timescale 1ns/10ps
`include "link_cfg_consts.vh"
module link_control_audio_config_regs #(
    parameter WORD_W = 32,
    parameter [7:0] DEVICE_ID = 8'h5a // arbitrary value
) (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    output reg rvalid_o,
    input wire fwd_link_up_i,
    input wire ack_request_i,
    output reg local_ack_o,
    output reg [1:0] slave_setup_hold_select_o,
    output reg [2:0] master_bit_rate_select_o,
    output reg [1:0] remote_timeout_select_o,
    output reg [11:0] remote_timeout_us_o,
    output reg timeout_enable_o,
    input wire fifo_empty_i,
    input wire [WORD_W-1:0] fifo_word_i,
    input wire sck_i,
    input wire ws_i,
    output wire [WORD_W-1:0] audio_word_o,
    output wire sck_o,
    output wire ws_o
);
////////////////////////////////////////////////////////////////////////
// storage, decode and field outputs
localparam [7:0] BRIDGE_RST = `RST_BRIDGE_CFG;
localparam [2:0] AUDIO_RST = `RST_AUDIO_CFG;
localparam integer AUDIO_BITS = 3;

reg [7:0] bridge_reg;
reg [7:0] bridge_next;
reg [2:0] audio_reg;
reg [2:0] audio_next;
reg [7:0] rdata_next;
reg local_ack_next;
reg [11:0] timeout_us_next;
reg timeout_enable_next;
wire bridge_wr;
wire audio_wr;
wire [1:0] timeout_sel;
wire link_down;
wire underflow_zero;
wire sck_invert;
wire ws_invert;

////////////////////////////////////////////////////////////////////////
// true when the offset selects the given register
function addr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
        addr_hit = (addr == ofs);
    end
endfunction

// typical remote timeout in microseconds, zero when off
function [11:0] timeout_us;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: begin
                timeout_us = `TIMEOUT_64US;
            end
            2'h1: begin
                timeout_us = `TIMEOUT_256US;
            end
            2'h2: begin
                timeout_us = `TIMEOUT_1024US;
            end
            default: begin
                timeout_us = 12'h000;
            end
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// write decode; identifier offset has no storage
assign bridge_wr = wr_en_i & addr_hit(addr_i, `OFS_BRIDGE_CFG);
assign audio_wr = wr_en_i & addr_hit(addr_i, `OFS_AUDIO_CFG);
assign timeout_sel = bridge_reg[`MSB_TIMEOUT:`LSB_TIMEOUT];
assign link_down = ~fwd_link_up_i;

always @* begin
    bridge_next = bridge_reg;
    audio_next = audio_reg;
    if (bridge_wr) begin
        bridge_next = wdata_i;
    end
    if (audio_wr) begin
        // reserved bits are not stored
        audio_next = wdata_i[AUDIO_BITS-1:0];
    end
end

always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        bridge_reg <= BRIDGE_RST;
        audio_reg <= AUDIO_RST;
    end else begin
        bridge_reg <= bridge_next;
        audio_reg <= audio_next;
    end
end

////////////////////////////////////////////////////////////////////////
// read path
always @* begin
    rdata_next = 8'h00;
    case (addr_i)
        `OFS_BRIDGE_CFG: begin
            rdata_next = bridge_reg;
        end
        `OFS_AUDIO_CFG: begin
            rdata_next = {5'h00, audio_reg};
        end
        `OFS_DEVICE_ID: begin
            rdata_next = DEVICE_ID;
        end
        default: begin
            rdata_next = 8'h00;
        end
    endcase
end

// read data holds until the next read strobe
always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        rdata_o <= 8'h00;
        rvalid_o <= 1'b0;
    end else begin
        rvalid_o <= rd_en_i;
        if (rd_en_i) begin
            rdata_o <= rdata_next;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// bridge control outputs
always @* begin
    local_ack_next = 1'b0;
    if (ack_request_i && link_down) begin
        local_ack_next = bridge_reg[`BIT_LOCAL_ACK];
    end
end

always @* begin
    timeout_us_next = timeout_us(timeout_sel);
end

// field value 11 switches the timeout off
always @* begin
    timeout_enable_next = 1'b1;
    if (timeout_sel == 2'h3) begin
        timeout_enable_next = 1'b0;
    end
end

always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        local_ack_o <= 1'b0;
    end else begin
        local_ack_o <= local_ack_next;
    end
end

always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        slave_setup_hold_select_o <= `RST_SETUP_HOLD;
        master_bit_rate_select_o <= `RST_BIT_RATE;
    end else begin
        slave_setup_hold_select_o <=
            bridge_reg[`MSB_SETUP_HOLD:`LSB_SETUP_HOLD];
        master_bit_rate_select_o <=
            bridge_reg[`MSB_BIT_RATE:`LSB_BIT_RATE];
    end
end

always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        remote_timeout_select_o <= `RST_TIMEOUT_SEL;
        remote_timeout_us_o <= `RST_TIMEOUT_US;
        timeout_enable_o <= 1'b1;
    end else begin
        remote_timeout_select_o <= timeout_sel;
        remote_timeout_us_o <= timeout_us_next;
        timeout_enable_o <= timeout_enable_next;
    end
end

////////////////////////////////////////////////////////////////////////
// audio output shaping
assign underflow_zero = audio_reg[`BIT_UNDERFLOW];
assign sck_invert = audio_reg[`BIT_SCK_INV];
assign ws_invert = audio_reg[`BIT_WS_INV];

audio_out_shaper #(
    .WORD_W(WORD_W)
) u_shaper (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .underflow_zero_i(underflow_zero),
    .sck_invert_i(sck_invert),
    .ws_invert_i(ws_invert),
    .fifo_empty_i(fifo_empty_i),
    .fifo_word_i(fifo_word_i),
    .sck_i(sck_i),
    .ws_i(ws_i),
    .audio_word_o(audio_word_o),
    .sck_o(sck_o),
    .ws_o(ws_o)
);
endmodule

// *** verification/audio_src.sv ***
`timescale 1ns/10ps
module audio_src (
    input wire run_i,
    output wire sck_o,
    output wire ws_o
);
    // clocks stand low outside a frame
    assign sck_o = run_i;
    assign ws_o = run_i;
endmodule

// *** verification/cfg_asserts.sv ***
`timescale 1ns/10ps
module cfg_asserts #(
    parameter [7:0] DEVICE_ID = 8'h5a
) (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] rdata_o,
    input wire rvalid_o,
    input wire fwd_link_up_i,
    input wire ack_request_i,
    input wire local_ack_o,
    input wire [1:0] remote_timeout_select_o,
    input wire [11:0] remote_timeout_us_o,
    input wire timeout_enable_o,
    input wire sck_i,
    input wire sck_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_no_ack_up: assert property (fwd_link_up_i |=> !local_ack_o)
        else $error("ack while link up");
    a_ack_needs_req: assert property (!ack_request_i |=> !local_ack_o)
        else $error("ack without request");
    a_sck_steady: assert property
        (!wr_en_i [*3] ##0 $stable(sck_i) |=> $stable(sck_o))
        else $error("sck output moved");
    a_timeout_off: assert property (remote_timeout_select_o == 2'b11
        |-> !timeout_enable_o && remote_timeout_us_o == 12'd0)
        else $error("timeout not off");
    a_timeout_long: assert property (remote_timeout_select_o == 2'b10
        |-> timeout_enable_o && remote_timeout_us_o == 12'd1024)
        else $error("timeout not 1024");
    a_read_valid: assert property (rd_en_i |=> rvalid_o)
        else $error("read valid missing");
    a_valid_only_read: assert property (!rd_en_i |=> !rvalid_o)
        else $error("read valid without read");
    a_id_read: assert property
        (rd_en_i && addr_i == 8'h1e |=> rdata_o == DEVICE_ID)
        else $error("identifier wrong");
    a_rdata_hold: assert property (!rd_en_i |=> $stable(rdata_o))
        else $error("read data moved");
endmodule
bind link_control_audio_config_regs cfg_asserts #(
    .DEVICE_ID(DEVICE_ID)
) u_chk (.*);

// *** verification/link_control_audio_config_regs_tb_top.sv ***
`timescale 1ns/10ps
module link_control_audio_config_regs_tb_top;
reg clk = 0, rst = 1, we = 0, re = 0, up = 1, rq = 0, emp = 1, run = 0;
reg [7:0] a = 0, d = 0;
reg [31:0] fw = 0;
wire [7:0] rdata;
wire [1:0] sh, tos;
wire [2:0] br;
wire [11:0] us;
wire [31:0] aw;
wire rv, lack, ten, sck, ws, so, wo;
integer mismatches = 0, n_compared = 0, cyc = 0, i;
link_control_audio_config_regs u_dut (.sys_clk_i(clk), .sys_rst_i(rst),
    .wr_en_i(we), .rd_en_i(re), .addr_i(a), .wdata_i(d), .rdata_o(rdata),
    .rvalid_o(rv), .fwd_link_up_i(up), .ack_request_i(rq),
    .local_ack_o(lack), .slave_setup_hold_select_o(sh),
    .master_bit_rate_select_o(br), .remote_timeout_select_o(tos),
    .remote_timeout_us_o(us), .timeout_enable_o(ten), .fifo_empty_i(emp),
    .fifo_word_i(fw), .sck_i(sck), .ws_i(ws), .audio_word_o(aw),
    .sck_o(so), .ws_o(wo));
audio_src u_src (.run_i(run), .sck_o(sck), .ws_o(ws));
initial forever #5 clk = ~clk;
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 500) begin
        mismatches = mismatches + 1;
        summarize;
    end
end
task summarize;
    begin
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end
endtask
task chk(input [95:0] nm, input [63:0] s, input [63:0] e);
    begin
        n_compared = n_compared + 1;
        if (s !== e) begin
            mismatches = mismatches + 1;
            $display("BAD %0s exp %h saw %h", nm, e, s);
        end
    end
endtask
task wr(input [7:0] x, input [7:0] y);
    begin
        @(negedge clk) a = x; d = y; we = 1;
        @(negedge clk) we = 0;
        @(negedge clk);
    end
endtask
task rd(input [7:0] x, input [7:0] e);
    begin
        @(negedge clk) a = x; re = 1;
        @(negedge clk) re = 0;
        chk("rvalid", rv, 1);
        chk("rdata", rdata, e);
    end
endtask
initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    rd(8'h1c, 8'hb6);
    chk("reset_fields", {sh, br, tos, us, ten},
        {2'b01, 3'b101, 2'b10, 12'd1024, 1'b1});
    up = 0;
    rq = 1;
    for (i = 0; i < 4; i = i + 1) begin
        wr(8'h1c, 8'h25 * i);
        chk("fields", {sh, br, tos, us, ten}, {i[1:0], i[2:0], i[1:0],
            (i < 3) ? 12'd64 << (2 * i) : 12'd0, i < 3});
        chk("local_ack", lack, 0);
    end
    wr(8'h1c, 8'h9c);
    chk("ack_rate", {lack, br}, {1'b1, 3'b111});
    up = 1;
    @(negedge clk) chk("ack_link_up", lack, 0);
    run = 1;
    emp = 0;
    fw = 32'hcafe0001;
    @(negedge clk) emp = 1;
    fw = 0;
    repeat (2) @(negedge clk);
    chk("audio_hold", {aw, so, wo}, {32'hcafe0001, 2'b11});
    wr(8'h1d, 8'hff);
    chk("audio_zero", {aw, so, wo}, 0);
    rd(8'h1d, 8'h07);
    wr(8'h1e, 8'h00);
    rd(8'h1e, 8'h5a);
    rd(8'h33, 8'h00);
    summarize;
end
endmodule
